/* File: hdl/readback_pkg.sv */
// package: frame layout, register map and reset values of the readback control block
package readback_pkg;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int unsigned FRAME_BITS  = 24;   // bits in one serial frame
  localparam int unsigned COUNT_WIDTH = 5;    // width of the bit counter
  localparam int unsigned ADDR_WIDTH  = 5;    // register address width
  localparam int unsigned DATA_WIDTH  = 16;   // register data width
  localparam logic [COUNT_WIDTH-1:0] FRAME_COUNT = 5'h18;  // full frame length
  // ****************************************
  // readback source control register
  // ****************************************
  localparam logic [ADDR_WIDTH-1:0] READBACK_SOURCE_ADDR = 5'h13;  // own address
  localparam int unsigned REG_WIDTH    = 22;     // implemented register width
  localparam logic [21:0] READBACK_SOURCE_RESET = 22'h130000;  // reset value
  localparam int unsigned FAULT_BIT    = 21;     // fault pin level, read only
  localparam int unsigned ECHO_LSB     = 16;     // address echo field
  localparam int unsigned MODE_LSB     = 5;      // reply format field
  localparam int unsigned SELECT_LSB   = 0;      // reply source index field
  localparam logic [ADDR_WIDTH-1:0] SELECT_RESET = 5'h00;  // no_operation_register
  localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR  = 5'h16;  // status register index
  localparam logic [ADDR_WIDTH-1:0] THIRD_ID_ADDR = 5'h1c; // third_identity_word
  // ****************************************
  // reply formats
  // ****************************************
  typedef enum logic [1:0] {
    REPLY_TWO_STAGE   = 2'h0,  // selected register next frame
    REPLY_AUTOSTATUS  = 2'h1,  // status every frame
    REPLY_SHARED      = 2'h2,  // status only after a valid write to any address
    REPLY_ALTERNATE   = 2'h3   // status and echo in turn
  } reply_mode_e;
  // ****************************************
  // frame carrier
  // ****************************************
  typedef struct packed {
    logic [2:0]            spare;  // upper bits, ignored
    logic [ADDR_WIDTH-1:0] addr;   // target register
    logic [DATA_WIDTH-1:0] data;   // register data
  } frame_s;
endpackage

/* File: hdl/pin_sync.sv */
// module: two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  // ****************************************
  // per bit double flop
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic first;  // read only by the second stage
      // first and second stage
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          first      <= 1'b0;
          pin_out[i] <= 1'b0;
        end else begin
          first      <= pin_in[i];
          pin_out[i] <= first;
        end
      end
    end
  endgenerate
endmodule

/* File: hdl/readback_control.sv */
// module: serial readback source and reply format control
`timescale 1ns/1ps
// Function
// - select field holds two-stage target address
// - register at 0x13 resets to 0x130000
// - format field bits 6:5, 00 two-stage default
// - format 01 shifts status every frame
// - format 10 sets flag after valid write
// - format 10 drives status only if flag
// - format 11 alternates status and echoed instruction
// - source index equals target register address
// - source index resets to no-operation register
// - bit 21 reads live fault pin level
module readback_control (
  // clock and reset
  input  wire logic                                clock,
  input  wire logic                                reset_n,
  // serial pins
  input  wire logic                                frame_sel_n,
  input  wire logic                                sclk,
  input  wire logic                                sdi,
  output logic                                     sdo,
  output logic                                     sdo_oe,
  // fault pin level
  input  wire logic                                fault_pin,
  // other registers of the device
  input  wire logic [readback_pkg::DATA_WIDTH-1:0] status_word,
  input  wire logic [readback_pkg::DATA_WIDTH-1:0] readback_word,
  output logic      [readback_pkg::ADDR_WIDTH-1:0] readback_index,
  output logic                                     write_strobe,
  output readback_pkg::frame_s                     write_word
);
  // ****************************************
  // pin synchronisation
  // ****************************************
  logic [3:0] pins_s;   // synchronised fault, active sel, sclk, sdi
  // select enters inverted: the flushed zero then reads as idle, no false edge after reset
  pin_sync #(.WIDTH(4)) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pin_in  ({fault_pin, ~frame_sel_n, sclk, sdi}),
    .pin_out (pins_s)
  );
  wire fault_s = pins_s[3];   // fault level
  wire sel_s   = ~pins_s[2];  // frame select, low active
  wire sclk_s  = pins_s[1];  // serial clock
  wire sdi_s   = pins_s[0];  // serial data in

  // ****************************************
  // edge detection
  // ****************************************
  logic sel_d;   // delayed frame select
  logic sclk_d;  // delayed serial clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sel_d  <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      sel_d  <= sel_s;
      sclk_d <= sclk_s;
    end
  end
  wire frame_start = sel_d & ~sel_s;              // select falls
  wire frame_end   = ~sel_d & sel_s;              // select rises
  wire sclk_rise   = ~sel_s & ~sclk_d & sclk_s;   // sample sdi
  wire sclk_fall   = ~sel_s & sclk_d & ~sclk_s;   // advance sdo

  // ****************************************
  // register state
  // ****************************************
  readback_pkg::reply_mode_e            mode;         // reply format
  logic [readback_pkg::ADDR_WIDTH-1:0]  select;       // reply source index
  logic                                 write_flag;   // valid write seen
  logic                                 alt_phase;    // 0 status, 1 echo
  logic [readback_pkg::FRAME_BITS-1:0]  last_frame;   // previous instruction
  logic [readback_pkg::FRAME_BITS-1:0]  shift_in;     // receive shifter
  logic [readback_pkg::FRAME_BITS-1:0]  shift_out;    // transmit shifter
  logic [readback_pkg::COUNT_WIDTH-1:0] bit_count;    // bits this frame

  // own register image, fault bit live
  wire [readback_pkg::REG_WIDTH-1:0] own_reg = {fault_s,
      readback_pkg::READBACK_SOURCE_ADDR,
      9'h000, mode, select};

  // ****************************************
  // frame decode
  // ****************************************
  readback_pkg::frame_s rx;  // received frame view
  assign rx = readback_pkg::frame_s'(shift_in);
  wire frame_full  = (bit_count == readback_pkg::FRAME_COUNT);
  wire valid_write = frame_end & frame_full;
  wire own_write   = valid_write & (rx.addr == readback_pkg::READBACK_SOURCE_ADDR);

  // ****************************************
  // reply selection
  // ****************************************
  // selected register; own register answered whole, live fault bit included
  wire own_select = (select == readback_pkg::READBACK_SOURCE_ADDR);
  wire [readback_pkg::FRAME_BITS-1:0] two_stage_word = own_select ?
      {2'h0, own_reg} : {3'h0, select, readback_word};
  wire [readback_pkg::FRAME_BITS-1:0] status_reply =
      {3'h0, readback_pkg::STATUS_ADDR, status_word};
  wire [readback_pkg::FRAME_BITS-1:0] reply_word =
      (mode == readback_pkg::REPLY_TWO_STAGE) ? two_stage_word :
      (mode == readback_pkg::REPLY_ALTERNATE && alt_phase) ? last_frame :
      status_reply;
  // shared select mode stays silent without a valid write to any address
  wire reply_drive = (mode != readback_pkg::REPLY_SHARED) | write_flag;

  // ****************************************
  // control register
  // ****************************************
  // format and source index written by a full frame to own address
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode   <= readback_pkg::REPLY_TWO_STAGE;
      select <= readback_pkg::SELECT_RESET;
    end else if (own_write) begin
      mode   <= readback_pkg::reply_mode_e'(rx.data[readback_pkg::MODE_LSB +: 2]);
      select <= rx.data[readback_pkg::SELECT_LSB +: readback_pkg::ADDR_WIDTH];
    end
  end
  // source index out to the register mux
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      readback_index <= readback_pkg::SELECT_RESET;
    end else begin
      readback_index <= own_write ?
          rx.data[readback_pkg::SELECT_LSB +: readback_pkg::ADDR_WIDTH] : select;
    end
  end

  // ****************************************
  // reply state
  // ****************************************
  // flag set by a valid write, consumed by the next frame; set wins
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      write_flag <= 1'b0;
    end else if (valid_write) begin
      write_flag <= 1'b1;
    end else if (frame_start) begin
      write_flag <= 1'b0;
    end
  end
  // alternate phase and echo capture at frame end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alt_phase  <= 1'b0;
      last_frame <= '0;
    end else if (frame_end) begin
      alt_phase  <= (mode == readback_pkg::REPLY_ALTERNATE) ? ~alt_phase : 1'b0;
      last_frame <= shift_in;
    end
  end

  // ****************************************
  // receive shifter
  // ****************************************
  // msb first, sampled on rising serial clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shift_in  <= '0;
      bit_count <= '0;
    end else if (frame_start) begin
      bit_count <= '0;
    end else if (sclk_rise) begin
      shift_in  <= {shift_in[readback_pkg::FRAME_BITS-2:0], sdi_s};
      bit_count <= frame_full ? bit_count : bit_count + 5'h01;
    end
  end

  // ****************************************
  // transmit shifter and pin
  // ****************************************
  // load at select fall, advance on falling serial clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shift_out <= '0;
      sdo       <= 1'b0;
      sdo_oe    <= 1'b0;
    end else if (frame_start) begin
      shift_out <= {reply_word[readback_pkg::FRAME_BITS-2:0], 1'b0};
      sdo       <= reply_word[readback_pkg::FRAME_BITS-1];
      sdo_oe    <= reply_drive;
    end else if (frame_end) begin
      sdo_oe    <= 1'b0;
    end else if (sclk_fall) begin
      shift_out <= {shift_out[readback_pkg::FRAME_BITS-2:0], 1'b0};
      sdo       <= shift_out[readback_pkg::FRAME_BITS-1];
    end
  end

  // ****************************************
  // write hand-off
  // ****************************************
  // every full frame is passed on to the other registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      write_strobe <= 1'b0;
      write_word   <= '0;
    end else begin
      write_strobe <= valid_write;
      if (valid_write) begin
        write_word <= rx;
      end
    end
  end
endmodule

/* File: verification/readback_control_checker.sv */
// port checks of the readback control block
`timescale 1ns/1ps
module readback_control_checker (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 reset_n,
  // watched ports
  input wire logic                 frame_sel_n,
  input wire logic                 sdo_oe,
  input wire logic [4:0]           readback_index,
  input wire logic                 write_strobe,
  input wire readback_pkg::frame_s write_word
);
  logic [1:0] mode;  // last written format
  logic       flag;  // full frame since frame start
  wire        own = write_word.addr == readback_pkg::READBACK_SOURCE_ADDR;  // hits us
  // shadow of format and shared flag
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode <= 2'h0;
      flag <= 1'b0;
    end else begin
      if (write_strobe && own) mode <= write_word.data[6:5];
      if (write_strobe || $fell(frame_sel_n)) flag <= write_strobe;
    end
  end
  // ****
  // checks
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence opens; $fell(frame_sel_n); endsequence
  sequence drives; ##[2:8] sdo_oe; endsequence
  sequence quiet; ##3 (!sdo_oe) [*8]; endsequence
  AST_DRIVES: assert property (opens ##0 (mode != 2'h2) |-> drives)
    else $error("reply not driven");
  AST_SHARED_ON: assert property (opens ##0 (mode == 2'h2 && flag) |-> drives)
    else $error("flagged reply not driven");
  AST_SHARED_OFF: assert property (opens ##0 (mode == 2'h2 && !flag) |-> quiet)
    else $error("unflagged reply driven");
  AST_IDLE: assert property (frame_sel_n [*8] |-> !sdo_oe)
    else $error("output driven outside frame");
  AST_PULSE: assert property (write_strobe |=> !write_strobe)
    else $error("strobe longer than one cycle");
  AST_AFTER: assert property (write_strobe |-> frame_sel_n && $past(frame_sel_n, 3))
    else $error("strobe inside frame");
  AST_SELECT: assert property (write_strobe && own |-> readback_index == write_word.data[4:0])
    else $error("index not taken from write");
  AST_HOLD: assert property ($changed(readback_index) |-> write_strobe && own)
    else $error("index changed without write");
  AST_RESET: assert property (disable iff (1'b0) !reset_n |=> readback_index == 5'h00)
    else $error("index not cleared by reset");
endmodule
bind readback_control readback_control_checker u_checker (.clock(clock), .reset_n(reset_n),
  .frame_sel_n(frame_sel_n), .sdo_oe(sdo_oe), .readback_index(readback_index),
  .write_strobe(write_strobe), .write_word(write_word));

/* File: verification/spi_host_model.sv */
// behavioural serial host that frames words to the block
`timescale 1ns/1ps
module spi_host_model (
  // serial pins
  output logic        frame_sel_n,
  output logic        sclk,
  output logic        sdi,
  input  wire logic   sdo,
  input  wire logic   sdo_oe,
  // captured reply {driven, word}
  output logic [24:0] reply,
  output logic        reply_done
);
  logic line;  // level seen on data line
  initial {frame_sel_n, sclk, sdi, line, reply_done} = 5'h10;
  // one frame, clock stands still outside it
  task automatic frame(input logic [23:0] tx, input int nbits);
    logic drv;
    drv = 1'b1;
    frame_sel_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi = tx[23-i];  // msb first
      #80 sclk = 1'b1;
      line = sdo_oe ? sdo : ~line;  // released line floats
      drv = drv & sdo_oe;
      reply = {drv, reply[22:0], line};
      #80 sclk = 1'b0;
    end
    sdi = ~sdi;  // data no longer valid
    #40 frame_sel_n = 1'b1;
    if (!drv) reply = 25'h0;
    reply_done = nbits == 24;
    #120 reply_done = 1'b0;  // gap between frames
  endtask
endmodule

/* File: verification/readback_control_tb_top.sv */
// self-checking bench of the readback control block
`timescale 1ns/1ps
module readback_control_tb_top;
  logic                 clock = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 fault_pin = 1'b0;
  logic [15:0]          status_word = 16'h0000;
  logic [15:0]          regs [32];  // other registers
  logic                 frame_sel_n, sclk, sdi, sdo, sdo_oe, write_strobe, reply_done;
  logic [4:0]           readback_index, sel = 5'h00, idx;
  logic [24:0]          reply;
  readback_pkg::frame_s write_word;
  wire  [15:0]          readback_word = regs[readback_index];
  integer               seed = 25884;
  int                   num_errors = 0;
  int                   check_count = 0;
  logic [24:0]          reply_q [$];  // expected replies
  logic [23:0]          write_q [$];  // expected writes
  logic [1:0]           mode = 2'h0;
  logic                 flag = 1'b0, phase = 1'b0;
  logic [23:0]          prev = 24'h0;  // last full frame
  always #5 clock = ~clock;
  readback_control DUT (.clock(clock), .reset_n(reset_n), .frame_sel_n(frame_sel_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .fault_pin(fault_pin),
    .status_word(status_word), .readback_word(readback_word),
    .readback_index(readback_index), .write_strobe(write_strobe), .write_word(write_word));
  spi_host_model host (.frame_sel_n(frame_sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .reply(reply), .reply_done(reply_done));
  task automatic compare_reply(input logic [24:0] exp, input logic [24:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED reply expected %h seen %h", exp, got);
    end
  endtask
  task automatic compare_write(input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED write_word expected %h seen %h", exp, got);
    end
  endtask
  // note expectations, run one frame, advance model
  task automatic send(input logic [4:0] addr, input logic [15:0] data, input int nbits);
    logic [20:0] st;
    @(negedge clock);
    status_word = 16'($random(seed));
    fault_pin = 1'($random(seed));
    st = {5'h16, status_word};
    if (nbits == 24) begin
      case (mode)
        2'h0: reply_q.push_back((sel == 5'h13) ?
            {3'h4, fault_pin, 5'h13, 9'h0, mode, sel} : {4'h8, sel, regs[sel]});
        2'h2: reply_q.push_back(flag ? {4'h8, st} : 25'h0);
        2'h3: reply_q.push_back(phase ? {1'b1, prev} : {4'h8, st});
        default: reply_q.push_back({4'h8, st});
      endcase
      write_q.push_back({3'h0, addr, data});
    end
    host.frame({3'h0, addr, data}, nbits);
    flag = nbits == 24;
    if (flag) begin
      prev = {3'h0, addr, data};
      phase = (mode == 2'h3) && !phase;
      if (addr == 5'h13) {mode, sel} = data[6:0];
    end
  endtask
  // results against oldest notes
  always @(posedge reply_done) compare_reply(reply_q.pop_front(), reply);
  always @(negedge clock) begin
    if (write_strobe === 1'b1) compare_write(write_q.pop_front(), write_word);
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 16'($random(seed));
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);  // synchroniser flush
    send(5'h13, 16'h0016, 24);  // no-op index after reset
    send(5'h13, 16'h0013, 24);
    send(5'h00, 16'h0000, 24);  // own register
    repeat (6) begin
      idx = 5'($random(seed));
      if (idx inside {[5'h0b:5'h0f], 5'h11, [5'h19:5'h1b]}) idx = 5'h1c;
      send(5'h13, {11'h000, idx}, 24);
    end
    send(5'h13, 16'h0020, 24);  // autostatus
    send(5'h13, 16'h0040, 24);  // shared select
    send(5'h07, 16'($random(seed)), 24);
    send(5'h07, 16'h1234, 12);  // short, refused
    send(5'h07, 16'h1234, 24);  // silent
    send(5'h13, 16'h0060, 24);  // alternate
    repeat (4) send(5'h02, 16'($random(seed)), 24);
    @(negedge clock) reset_n = 1'b0;
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);  // synchroniser flush
    {mode, sel, flag, phase} = 9'h0;
    send(5'h00, 16'h0000, 24);
    report_and_stop();
  end
  // about 20 frames of 4 us, far below this
  initial begin
    #500000;
    num_errors++;
    report_and_stop();
  end
endmodule
